// ### rtl/kcsp_top.sv
// keypad code serial port: keypad decode, serial shift port, tone code mux
// assumes pins are asynchronous to mclk; shift clock far slower than mclk
// Function
// - each key maps to a 4-bit tone code
// - manual mode sends key code out serially
// - msb first, bits move on falling edge
// - load control alternates load and shift out
// - manual read takes six clock cycles
// - automatic mode shifts four bits in, msb first
// - automatic mode tone outputs ignore the keypad
// - inhibit high suppresses tone output
// - key valid only for exactly one key
// - tone active flag follows tone enable
// - idle manual data line reads one
// - inhibit leaves keypad decoding running
`timescale 1ns/10ps
`default_nettype none
module kcsp_top
  import kcsp_pkg::*;
(
  // clock and reset
  input  wire logic                         mclk,
  input  wire logic                         sys_rst,
  // avalon-mm slave
  input  wire logic [kcsp_pkg::KCSP_AW-1:0] avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [kcsp_pkg::KCSP_DW-1:0] avs_writedata,
  input  wire logic [3:0]                   avs_byteenable,
  output logic      [kcsp_pkg::KCSP_DW-1:0] avs_readdata,
  output logic                              avs_waitrequest,
  output logic                              irq,
  // keypad pins
  input  wire logic [3:0]                   row_n,
  input  wire logic [3:0]                   col,
  // host port pins
  input  wire logic                         shift_clock_n,
  input  wire logic                         transfer_direction_select,
  input  wire logic                         tone_inhibit,
  input  wire logic                         serial_data_i,
  output logic                              serial_data_o,
  output logic                              serial_data_oe,
  output logic                              single_key_valid,
  output logic                              tone_active_mute,
  // tone generator
  output logic      [3:0]                   key_code_bits
);
  import kcsp_pkg::*;

  // ==========================================================
  // functions
  function automatic logic onehot4(input logic [3:0] v);
    onehot4 = (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
  endfunction : onehot4

  // line 1 -> 11, 2 -> 01, 3 -> 10, 4 -> 00
  function automatic logic [1:0] enc2(input logic [3:0] v);
    enc2 = {v[0] | v[2], v[0] | v[1]};
  endfunction : enc2

  // ==========================================================
  // pin synchronisers
  logic [KCSP_SYNC_W-1:0] pins_s;
  logic [3:0]             row_s;
  logic [3:0]             col_s;
  logic                   clk_s;
  logic                   dir_s;
  logic                   inh_s;
  logic                   din_s;

  kcsp_sync #(
    .WIDTH (KCSP_SYNC_W)
  ) u_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    // clock pin enters inverted so the flops' reset value matches its idle high level
    .pin_in   ({~row_n, col, ~shift_clock_n,
                transfer_direction_select, tone_inhibit,
                serial_data_i}),
    .pin_sync (pins_s)
  );

  assign row_s = pins_s[11:8];
  assign col_s = pins_s[7:4];
  assign clk_s = ~pins_s[3];
  assign dir_s = pins_s[2];
  assign inh_s = pins_s[1];
  assign din_s = pins_s[0];

  // ==========================================================
  // registers and state
  logic [KCSP_EV_W-1:0]   st_q;
  logic [KCSP_EV_W-1:0]   mask_q;
  logic                   pad16_q;
  logic                   clk_prev_q;
  logic                   dir_q;
  logic                   kv_q;
  kcsp_mstate_t           ms_q;
  kcsp_mstate_t           ms_d;
  logic [2:0]             cnt_q;
  logic [2:0]             cnt_d;
  logic [1:0]             acnt_q;
  logic [3:0]             sreg_q;
  logic [3:0]             sreg_d;
  logic [3:0]             auto_code_q;
  logic                   auto_valid_q;
  logic                   ack_q;
  logic [KCSP_DW-1:0]     rdata_d;

  // ==========================================================
  // keypad decode, unaffected by inhibit
  wire [3:0] col_use  = col_s & {pad16_q, 3'h7};
  wire       kv_w     = onehot4(row_s) & onehot4(col_use);
  wire [3:0] key_code = {enc2(col_use), enc2(row_s)};

  // ==========================================================
  // serial link events
  wire fall     = clk_prev_q & ~clk_s;
  wire dir_chg  = dir_s != dir_q;
  wire man_fall = fall & ~dir_q & ~dir_chg;
  wire aut_fall = fall & dir_q & ~dir_chg;
  wire aut_done = aut_fall & (acnt_q == KCSP_LOAD_EDGE);
  wire rd_done  = man_fall & (ms_q == KCSP_M_SHIFT)
                & (cnt_q == KCSP_READ_EDGE - 3'h1);

  // tone source: keypad in manual mode, shifted code in automatic
  wire [3:0] tone_code = dir_q ? auto_code_q : key_code;
  wire       src_valid = dir_q ? auto_valid_q : kv_q;
  wire       tone_en   = src_valid & ~inh_s;

  // ==========================================================
  // manual read sequencer
  always_comb begin
    ms_d   = ms_q;
    cnt_d  = cnt_q;
    sreg_d = sreg_q;
    if (dir_chg) begin
      ms_d   = KCSP_M_LOAD;
      cnt_d  = 3'h0;
      sreg_d = KCSP_IDLE_CODE;
    end else if (dir_q) begin
      if (aut_fall) begin
        sreg_d = {sreg_q[2:0], din_s};
      end
    end else begin
      unique case (ms_q)
        KCSP_M_LOAD: begin
          // keep tracking the key so a read sees the current code
          sreg_d = kv_q ? key_code : KCSP_IDLE_CODE;
          if (man_fall) begin
            ms_d   = KCSP_M_SHIFT;
            cnt_d  = 3'h1;
            sreg_d = {sreg_q[2:0], 1'h1};
          end
        end
        KCSP_M_SHIFT: begin
          if (man_fall) begin
            if (cnt_q == KCSP_LAST_EDGE) begin
              ms_d  = KCSP_M_LOAD;
              cnt_d = 3'h0;
            end else begin
              cnt_d  = cnt_q + 3'h1;
              sreg_d = {sreg_q[2:0], 1'h1};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ms_q       <= KCSP_M_LOAD;
      cnt_q      <= 3'h0;
      sreg_q     <= KCSP_IDLE_CODE;
      clk_prev_q <= 1'h1;
      dir_q      <= 1'h0;
    end else begin
      ms_q       <= ms_d;
      cnt_q      <= cnt_d;
      sreg_q     <= sreg_d;
      clk_prev_q <= clk_s;
      dir_q      <= dir_s;
    end
  end

  // ==========================================================
  // automatic load counter and code
  always_ff @(posedge mclk) begin
    if (sys_rst || dir_chg) begin
      acnt_q       <= 2'h0;
      auto_valid_q <= 1'h0;
      auto_code_q  <= KCSP_IDLE_CODE;
    end else if (aut_fall) begin
      acnt_q <= acnt_q + 2'h1;
      if (aut_done) begin
        auto_valid_q <= 1'h1;
        auto_code_q  <= {sreg_q[2:0], din_s};
      end
    end
  end

  // ==========================================================
  // pin outputs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      kv_q             <= 1'h0;
      single_key_valid <= 1'h0;
      tone_active_mute <= 1'h0;
      key_code_bits    <= KCSP_IDLE_CODE;
      serial_data_oe   <= 1'h1;
    end else begin
      kv_q             <= kv_w;
      single_key_valid <= kv_w;
      tone_active_mute <= tone_en;
      key_code_bits    <= tone_code;
      serial_data_oe   <= ~dir_s;
    end
  end

  // a register bit, so the line never glitches between edges
  assign serial_data_o = sreg_q[3];

  // ==========================================================
  // avalon slave: one wait cycle on every access
  wire access  = avs_read | avs_write;
  wire wr_go   = avs_write & ack_q & avs_byteenable[0];
  wire sel_st  = avs_address == KCSP_OFF_STATUS;
  wire sel_msk = avs_address == KCSP_OFF_MASK;
  wire sel_cod = avs_address == KCSP_OFF_CODE;
  wire sel_ctl = avs_address == KCSP_OFF_CTRL;
  wire [KCSP_EV_W-1:0] ev  = {aut_done, rd_done, kv_w & ~kv_q};
  wire [KCSP_EV_W-1:0] clr = {KCSP_EV_W{wr_go & sel_st}}
                           & avs_writedata[KCSP_EV_W-1:0];

  assign avs_waitrequest = access & ~ack_q;
  assign irq             = |(st_q & mask_q);

  always_comb begin
    rdata_d = '0;
    if (sel_st) begin
      rdata_d[KCSP_EV_W-1:0] = st_q;
    end else if (sel_msk) begin
      rdata_d[KCSP_EV_W-1:0] = mask_q;
    end else if (sel_cod) begin
      rdata_d[KCSP_CF_TONE+:4] = key_code_bits;
      rdata_d[KCSP_CF_KEY+:4]  = key_code;
      rdata_d[KCSP_CF_KV]      = single_key_valid;
      rdata_d[KCSP_CF_TA]      = tone_active_mute;
      rdata_d[KCSP_CF_DIR]     = dir_q;
      rdata_d[KCSP_CF_AV]      = auto_valid_q;
      rdata_d[KCSP_CF_CNT+:3]  = cnt_q;
    end else if (sel_ctl) begin
      rdata_d[KCSP_CTRL_PAD16] = pad16_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ack_q        <= 1'h0;
      avs_readdata <= '0;
    end else begin
      ack_q        <= access & ~ack_q;
      avs_readdata <= rdata_d;
    end
  end

  // set beats clear so no event is lost
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q    <= '0;
      mask_q  <= KCSP_MASK_RST;
      pad16_q <= KCSP_PAD16_RST;
    end else begin
      st_q <= (st_q & ~clr) | ev;
      if (wr_go && sel_msk) begin
        mask_q <= avs_writedata[KCSP_EV_W-1:0];
      end
      if (wr_go && sel_ctl) begin
        pad16_q <= avs_writedata[KCSP_CTRL_PAD16];
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence s_read_end;
    man_fall && ms_q == KCSP_M_SHIFT && cnt_q == KCSP_LAST_EDGE;
  endsequence

  sequence s_back_to_load;
    ms_q == KCSP_M_LOAD && cnt_q == 3'h0;
  endsequence

  chk_idle_line_one: assert property (
    !dir_q && !dir_chg && ms_q == KCSP_M_LOAD && !kv_q
      |=> serial_data_o)
    else $error("idle manual data line not one");

  chk_manual_drives: assert property (
    !dir_s ##1 !dir_s |-> serial_data_oe)
    else $error("data line not driven in manual mode");

  chk_msb_first: assert property (
    man_fall && ms_q == KCSP_M_SHIFT && cnt_q < 3'h3
      |=> serial_data_o == $past(sreg_q[2]))
    else $error("serial bit order broken");

  chk_reload_cycle: assert property (
    s_read_end |=> s_back_to_load)
    else $error("register not reloaded after read");

  chk_six_edges: assert property (
    ms_q == KCSP_M_SHIFT |-> cnt_q >= 3'h1 && cnt_q <= KCSP_LAST_EDGE)
    else $error("manual edge count out of range");

  chk_auto_load: assert property (
    aut_done |=> auto_valid_q
      && auto_code_q == {$past(sreg_q[2:0]), $past(din_s)})
    else $error("automatic code not loaded on fourth edge");

  chk_keypad_ignored: assert property (
    dir_q |=> key_code_bits == $past(auto_code_q))
    else $error("keypad reached tones in automatic mode");

  chk_inhibit_mutes: assert property (
    inh_s |=> !tone_active_mute)
    else $error("tone active while inhibited");

  chk_key_valid: assert property (
    single_key_valid |-> $past(kv_w))
    else $error("key valid without exactly one key");

  chk_keypad_live: assert property (
    inh_s && kv_w |=> single_key_valid)
    else $error("inhibit stopped keypad decoding");

  chk_tone_flag: assert property (
    ##1 tone_active_mute == $past(tone_en))
    else $error("tone active flag out of step");

endmodule : kcsp_top
`default_nettype wire

// ### rtl/kcsp_pkg.sv
// keypad code serial port: shared constants and types
// assumes a 32-bit avalon-mm slave with byte addresses
package kcsp_pkg;

  // ==========================================================
  // register map
  localparam int          KCSP_AW         = 4;
  localparam int          KCSP_DW         = 32;
  localparam logic [3:0]  KCSP_OFF_STATUS = 4'h0;
  localparam logic [3:0]  KCSP_OFF_MASK   = 4'h4;
  localparam logic [3:0]  KCSP_OFF_CODE   = 4'h8;
  localparam logic [3:0]  KCSP_OFF_CTRL   = 4'hc;

  // ==========================================================
  // status / mask bits
  localparam int          KCSP_EV_W       = 3;
  localparam int          KCSP_EV_KEY     = 0;
  localparam int          KCSP_EV_READ    = 1;
  localparam int          KCSP_EV_LOAD    = 2;
  localparam logic [2:0]  KCSP_MASK_RST   = 3'h0;

  // ==========================================================
  // ctrl bits
  localparam int          KCSP_CTRL_PAD16 = 0;
  localparam logic        KCSP_PAD16_RST  = 1'h1;

  // ==========================================================
  // code register fields
  localparam int          KCSP_CF_TONE    = 0;
  localparam int          KCSP_CF_KEY     = 4;
  localparam int          KCSP_CF_KV      = 8;
  localparam int          KCSP_CF_TA      = 9;
  localparam int          KCSP_CF_DIR     = 10;
  localparam int          KCSP_CF_AV      = 11;
  localparam int          KCSP_CF_CNT     = 12;

  // ==========================================================
  // serial link
  localparam int          KCSP_CODE_W     = 4;
  localparam int          KCSP_PAD_N      = 4;
  localparam logic [3:0]  KCSP_IDLE_CODE  = 4'hf;
  localparam logic [2:0]  KCSP_LAST_EDGE  = 3'h5;
  localparam logic [2:0]  KCSP_READ_EDGE  = 3'h4;
  localparam logic [1:0]  KCSP_LOAD_EDGE  = 2'h3;
  localparam int          KCSP_SYNC_W     = 12;

  typedef enum logic {
    KCSP_M_LOAD,
    KCSP_M_SHIFT
  } kcsp_mstate_t;

endpackage : kcsp_pkg

// ### rtl/kcsp_sync.sv
// two-flop synchroniser for a vector of independent pin levels
// assumes each bit is a slow level; no bus coherence is implied
`timescale 1ns/10ps
`default_nettype none
module kcsp_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  // pins
  input  wire logic [WIDTH-1:0] pin_in,
  // synchronised levels
  output logic      [WIDTH-1:0] pin_sync
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_q   <= '0;
      pin_sync <= '0;
    end else begin
      meta_q   <= pin_in;
      pin_sync <= meta_q;
    end
  end
endmodule : kcsp_sync
`default_nettype wire

// ### verif/kcsp_host.sv
// host-side serial master model for the keypad code serial port pins
// assumes the bench shares mclk; one shift clock period is ten mclk (80 ns)
`timescale 1ns/10ps
`default_nettype none
module kcsp_host (
  // clock
  input  wire logic mclk,
  // link pins
  output logic      shift_clock_n,
  output logic      transfer_direction_select,
  output logic      tone_inhibit,
  output logic      host_dout,
  // resolved data line
  input  wire logic io_line
);
  // ==========================================================
  // pin levels
  initial begin
    shift_clock_n             = 1'h1;
    transfer_direction_select = 1'h0;
    tone_inhibit              = 1'h0;
    host_dout                 = 1'h1;
  end

  // ==========================================================
  // one shift clock; it stands high between frames
  // host timing is scaled down with the clock, keeping the same order
  task automatic pulse();
    @(posedge mclk);
    shift_clock_n <= 1'h0;
    repeat (5) @(posedge mclk);
    shift_clock_n <= 1'h1;
    repeat (4) @(posedge mclk);
  endtask : pulse

  task automatic set_pins(input logic d, input logic t);
    @(posedge mclk);
    transfer_direction_select <= d;
    tone_inhibit              <= t;
    repeat (8) @(posedge mclk);
  endtask : set_pins

  // ==========================================================
  // manual read: sample late in each period, six clocks in all
  task automatic read_code(output logic [3:0] code);
    repeat (8) @(posedge mclk);
    for (int i = 0; i < 6; i++) begin
      @(negedge mclk);
      if (i < 4) code[3-i] = io_line;
      pulse();
    end
  endtask : read_code

  // automatic load: inhibit, then direction, then four bits msb first
  task automatic load_code(input logic [3:0] code);
    @(posedge mclk);
    tone_inhibit <= 1'h1;
    repeat (4) @(posedge mclk);
    transfer_direction_select <= 1'h1;
    repeat (8) @(posedge mclk);
    for (int i = 3; i >= 0; i--) begin
      host_dout <= code[i];
      pulse();
    end
    // a released line must not keep showing the last bit
    host_dout <= ~code[0];
  endtask : load_code
endmodule : kcsp_host
`default_nettype wire

// ### verif/tb_kcsp_top.sv
// self-checking bench for the keypad code serial port
// assumes kcsp_host drives the link pins; keypad and avalon bus driven here
`timescale 1ns/10ps
`default_nettype none
module tb_kcsp_top;
  import kcsp_pkg::*;
  logic        mclk;
  logic        sys_rst;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic [3:0]  row_n;
  logic [3:0]  col;
  logic        sclk_n;
  logic        dir;
  logic        inh;
  logic        host_dout;
  logic        io_line;
  logic        sd_o;
  logic        sd_oe;
  logic        kv;
  logic        ta;
  logic [3:0]  kcode;
  logic [31:0] rd;
  logic [3:0]  got;
  int          n_fail;
  int          num_checks;

  assign io_line = sd_oe ? sd_o : host_dout;

  kcsp_top dut_u (
    .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .row_n(row_n), .col(col), .shift_clock_n(sclk_n), .transfer_direction_select(dir),
    .tone_inhibit(inh), .serial_data_i(io_line), .serial_data_o(sd_o),
    .serial_data_oe(sd_oe), .single_key_valid(kv), .tone_active_mute(ta),
    .key_code_bits(kcode));

  kcsp_host host_u (
    .mclk(mclk), .shift_clock_n(sclk_n), .transfer_direction_select(dir),
    .tone_inhibit(inh), .host_dout(host_dout), .io_line(io_line));

  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] a);
    num_checks++;
    if (a !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, e, a);
    end
  endtask : chk

  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
  endtask : wait_n

  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= d;
    // waitrequest and readdata are seen as they stand at this edge
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 20);
    q = avs_readdata;
    if (avs_waitrequest !== 1'h0) n_fail++;
    avs_write <= 1'h0;
    avs_read  <= 1'h0;
  endtask : av

  // row index 0..3 and column index 0..3 map to 11, 01, 10, 00
  function automatic logic [3:0] kc(input int r, input int c);
    logic [1:0] m [4];
    m = '{2'h3, 2'h1, 2'h2, 2'h0};
    return {m[c], m[r]};
  endfunction : kc

  task automatic press(input int r, input int c);
    @(posedge mclk);
    row_n <= ~(4'h1 << r);
    col   <= 4'h1 << c;
    wait_n(8);
  endtask : press

  // ==========================================================
  // scenarios
  task automatic t_reset();
    wait_n(2);
    chk("data_idle", 1'h1, sd_o);
    chk("oe_idle", 1'h1, sd_oe);
    chk("kv_idle", 1'h0, kv);
    chk("ta_idle", 1'h0, ta);
    av(1'h0, KCSP_OFF_CTRL, 32'h0, rd);
    chk("ctrl_rst", 32'h1, rd);
    av(1'h0, KCSP_OFF_MASK, 32'h0, rd);
    chk("mask_rst", 32'h0, rd);
    av(1'h0, 4'h2, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    $display("test reset done");
  endtask : t_reset

  task automatic t_keys();
    for (int r = 0; r < 4; r++) begin
      for (int c = 0; c < 4; c++) begin
        press(r, c);
        chk("key_valid", 1'h1, kv);
        chk("tone_code", kc(r, c), kcode);
        chk("tone_on", 1'h1, ta);
        chk("data_msb", kc(r, c) >> 3, sd_o);
      end
    end
    @(posedge mclk);
    col <= 4'h3;
    wait_n(8);
    chk("two_keys", 1'h0, kv);
    av(1'h1, KCSP_OFF_CTRL, 32'h0, rd);
    press(0, 3);
    chk("pad12_col4", 1'h0, kv);
    av(1'h1, KCSP_OFF_CTRL, 32'h1, rd);
    press(0, 0);
    row_n <= 4'hf;
    col   <= 4'h0;
    wait_n(8);
    $display("test keys done");
  endtask : t_keys

  task automatic t_read();
    av(1'h1, KCSP_OFF_STATUS, 32'h7, rd);
    av(1'h1, KCSP_OFF_MASK, 32'h2, rd);
    press(2, 1);
    for (int k = 0; k < 2; k++) begin
      host_u.read_code(got);
      chk("serial_code", kc(2, 1), got);
      chk("reloaded", kc(2, 1) >> 3, sd_o);
    end
    chk("irq_read", 1'h1, irq);
    av(1'h0, KCSP_OFF_STATUS, 32'h0, rd);
    chk("status", 32'h3, rd);
    av(1'h1, KCSP_OFF_STATUS, 32'h2, rd);
    wait_n(2);
    chk("irq_clear", 1'h0, irq);
    host_u.set_pins(1'h0, 1'h1);
    chk("inhibited", 1'h0, ta);
    chk("kv_kept", 1'h1, kv);
    host_u.set_pins(1'h0, 1'h0);
    $display("test read done");
  endtask : t_read

  task automatic t_auto();
    av(1'h1, KCSP_OFF_MASK, 32'h4, rd);
    press(0, 0);
    host_u.load_code(4'h6);
    wait_n(8);
    chk("oe_auto", 1'h0, sd_oe);
    chk("auto_code", 4'h6, kcode);
    chk("ta_inhib", 1'h0, ta);
    chk("irq_load", 1'h1, irq);
    host_u.set_pins(1'h1, 1'h0);
    chk("ta_auto", 1'h1, ta);
    press(1, 2);
    chk("pad_ignored", 4'h6, kcode);
    av(1'h0, KCSP_OFF_CODE, 32'h0, rd);
    chk("code_reg", 32'hf96, rd);
    av(1'h1, KCSP_OFF_STATUS, 32'h7, rd);
    wait_n(2);
    chk("irq_off", 1'h0, irq);
    host_u.set_pins(1'h0, 1'h0);
    chk("oe_manual", 1'h1, sd_oe);
    $display("test auto done");
  endtask : t_auto

  // ==========================================================
  // run control
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end

  initial begin
    sys_rst       = 1'h1;
    avs_address   = 4'h0;
    avs_read      = 1'h0;
    avs_write     = 1'h0;
    avs_writedata = 32'h0;
    row_n         = 4'hf;
    col           = 4'h0;
    n_fail        = 0;
    num_checks    = 0;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'h0;
    t_reset();
    t_keys();
    t_read();
    t_auto();
    give_verdict();
  end

  // the tests need about five hundred cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end
endmodule : tb_kcsp_top
`default_nettype wire
